/* src/lcdfb_pkg.sv */
// constants for the lcd frame buffer address generator
package lcdfb_pkg;

  // ----------------------------------------------------------------
  // register indices on the indexed i/o port
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RQ2_START_HI  = 8'h43;
  localparam logic [7:0] IDX_RQ1_OFS_LO    = 8'h44;
  localparam logic [7:0] IDX_RD_ADDR_OVF   = 8'h45;
  localparam logic [7:0] IDX_WR_START_LO   = 8'h46;
  localparam logic [7:0] IDX_WR_START_HI   = 8'h47;
  localparam logic [7:0] IDX_WR_OFS_LO     = 8'h48;
  localparam logic [7:0] IDX_WR_ADDR_OVF   = 8'h49;
  localparam logic [7:0] IDX_REQ_LEVELS    = 8'h4A;
  localparam logic [7:0] IDX_RQ2_OFS_LO    = 8'h4B;
  localparam logic [7:0] IDX_RQ2_OFS_OVF   = 8'h4C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RD_OVF_Q1_OFS_LSB   = 6;  // offset bits 9:8 of queue 1
  localparam int RD_OVF_Q1_START_LSB = 3;  // start bits 18:16 of queue 1
  localparam int RD_OVF_Q2_START_LSB = 0;  // start bits 18:16 of queue 2
  localparam int WR_OVF_START_LSB    = 2;  // write start bits 18:16
  localparam int WR_OVF_OFS_LSB      = 0;  // write offset bits 9:8
  localparam int LVL_Q2_LSB          = 6;
  localparam int LVL_Q1_LSB          = 4;
  localparam int LVL_WR_LSB          = 0;
  localparam int Q2_OFS_OVF_LSB      = 6;

  // ----------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WR_OVF_MASK     = 8'h1F;
  localparam logic [7:0] REQ_LEVELS_MASK = 8'hF3;
  localparam logic [7:0] Q2_OFS_OVF_MASK = 8'hC0;
  localparam logic [7:0] REQ_LEVELS_RST  = 8'h44;
  localparam logic [7:0] RDATA_RST       = 8'h00;

  // ----------------------------------------------------------------
  // panel type and request level encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PANEL_DSTN      = 2'b01;
  localparam logic [1:0] LVL_CODE_4      = 2'b00;
  localparam logic [1:0] LVL_CODE_8      = 2'b01;
  localparam int         LVL_ENTRIES_4   = 4;
  localparam int         LVL_ENTRIES_8   = 8;
  localparam int         LVL_ENTRIES_12  = 12;

  // address layout: line counters count 8-byte units, address bit 3 up
  localparam int QW_SHIFT = 3;

endpackage : lcdfb_pkg

/* src/lcdfb_addr_gen.sv */
// lcd frame buffer read/write line address generator and queue requests
//
// Overview of operation
// - second read start used only for dstn panel with virtual refresh on
// - second read start high byte gives read address bits 18..11
// - first read queue next line = current line plus 10-bit offset
// - first read offset low byte lands on read address bits 10..3
// - overflow bits 7..6 give first offset bits landing on address 12..11
// - overflow bits 5..3 give first read start address bits 21..19
// - with dstn and virtual refresh, first read queue fetches upper half
// - overflow bits 2..0 give second read start address bits 21..19
// - write start low byte lands on write address bits 10..3
// - write start high byte lands on write address bits 18..11
// - write overflow start bits land on write address bits 21..19
// - write next line = current line plus 10-bit write offset
// - write overflow bits 1..0 are offset bits 9..8, address 12..11
// - second read request when empty entries reach 4, 8 or 12
// - first read request when empty entries reach 4, 8 or 12
// - write request when filled entries reach 4, 8 or 12
// - request level register resets to 44h, address registers undefined
// - second read queue steps lines by its own 10-bit offset
// - offset overflow bits 7..6 are second offset bits 9..8
`timescale 1ns/1ps

module lcdfb_addr_gen
  import lcdfb_pkg::*;
#(
  parameter int ADDR_W = 22,  // display memory byte address width
  parameter int CNT_W  = 5    // width of the queue level counts
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // indexed register port
  input  wire logic [7:0]        reg_idx_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // settings held in neighbouring registers
  input  wire logic [1:0]        panel_type_select_i,
  input  wire logic              virtual_refresh_control_i,
  input  wire logic [15:0]       first_read_start_i,
  input  wire logic [7:0]        second_read_start_lo_i,
  // line sequencing strobes
  input  wire logic              frame_start_i,
  input  wire logic              rq1_line_next_i,
  input  wire logic              rq2_line_next_i,
  input  wire logic              wq_line_next_i,
  // queue levels
  input  wire logic [CNT_W-1:0]  rq1_empty_i,
  input  wire logic [CNT_W-1:0]  second_read_queue_empty_i,
  input  wire logic [CNT_W-1:0]  write_queue_filled_i,
  // addresses and requests toward the memory arbiter
  output logic [ADDR_W-1:0]      rq1_addr_o,
  output logic [ADDR_W-1:0]      rq2_addr_o,
  output logic [ADDR_W-1:0]      wq_addr_o,
  output logic                   rq1_req_o,
  output logic                   rq2_req_o,
  output logic                   wq_req_o,
  output logic                   upper_panel_mode_o
);

  localparam int LINE_W = ADDR_W - QW_SHIFT;  // counter in 8-byte units

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // level code to entry count; used by all three request paths
  function automatic logic [CNT_W-1:0] lvl_entries(input logic [1:0] code);
    logic [CNT_W-1:0] n;
    n = CNT_W'(LVL_ENTRIES_12);
    if (code == LVL_CODE_4) begin
      n = CNT_W'(LVL_ENTRIES_4);
    end else if (code == LVL_CODE_8) begin
      n = CNT_W'(LVL_ENTRIES_8);
    end
    return n;
  endfunction : lvl_entries

  // line counter to byte address, low three bits zero
  function automatic logic [ADDR_W-1:0] to_addr(input logic [LINE_W-1:0] l);
    return {l, {QW_SHIFT{1'b0}}};
  endfunction : to_addr

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] rq2_start_hi_q;
  logic [7:0] rq1_ofs_lo_q;
  logic [7:0] rd_addr_ovf_q;
  logic [7:0] wr_start_lo_q;
  logic [7:0] wr_start_hi_q;
  logic [7:0] wr_ofs_lo_q;
  logic [7:0] wr_addr_ovf_q;
  logic [7:0] req_levels_q;
  logic [7:0] rq2_ofs_lo_q;
  logic [7:0] rq2_ofs_ovf_q;
  logic [7:0] rdata_q;

  // address and offset registers have no reset: contents are undefined
  // until software programs them, which saves reset routing
  always_ff @(posedge core_clk_i) begin
    if (reg_wr_i) begin
      case (reg_idx_i)
        IDX_RQ2_START_HI: rq2_start_hi_q <= reg_wdata_i;
        IDX_RQ1_OFS_LO:   rq1_ofs_lo_q   <= reg_wdata_i;
        IDX_RD_ADDR_OVF:  rd_addr_ovf_q  <= reg_wdata_i;
        IDX_WR_START_LO:  wr_start_lo_q  <= reg_wdata_i;
        IDX_WR_START_HI:  wr_start_hi_q  <= reg_wdata_i;
        IDX_WR_OFS_LO:    wr_ofs_lo_q    <= reg_wdata_i;
        IDX_WR_ADDR_OVF:  wr_addr_ovf_q  <= reg_wdata_i & WR_OVF_MASK;
        IDX_RQ2_OFS_LO:   rq2_ofs_lo_q   <= reg_wdata_i;
        // reserved low bits are not stored
        IDX_RQ2_OFS_OVF:  rq2_ofs_ovf_q  <= reg_wdata_i & Q2_OFS_OVF_MASK;
        default: ;
      endcase
    end
  end

  // request levels: the only indexed register with a defined power-on value
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      req_levels_q <= REQ_LEVELS_RST;
    end else if (reg_wr_i && reg_idx_i == IDX_REQ_LEVELS) begin
      // bits 3:2 are reserved: writes leave them at the power-on value
      req_levels_q <= (reg_wdata_i & REQ_LEVELS_MASK) |
                      (req_levels_q & ~REQ_LEVELS_MASK);
    end
  end

  // read data is registered one cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= RDATA_RST;
    end else if (reg_rd_i) begin
      case (reg_idx_i)
        IDX_RQ2_START_HI: rdata_q <= rq2_start_hi_q;
        IDX_RQ1_OFS_LO:   rdata_q <= rq1_ofs_lo_q;
        IDX_RD_ADDR_OVF:  rdata_q <= rd_addr_ovf_q;
        IDX_WR_START_LO:  rdata_q <= wr_start_lo_q;
        IDX_WR_START_HI:  rdata_q <= wr_start_hi_q;
        IDX_WR_OFS_LO:    rdata_q <= wr_ofs_lo_q;
        IDX_WR_ADDR_OVF:  rdata_q <= wr_addr_ovf_q & WR_OVF_MASK;
        IDX_REQ_LEVELS:   rdata_q <= req_levels_q;
        IDX_RQ2_OFS_LO:   rdata_q <= rq2_ofs_lo_q;
        IDX_RQ2_OFS_OVF:  rdata_q <= rq2_ofs_ovf_q & Q2_OFS_OVF_MASK;
        default:          rdata_q <= RDATA_RST;  // unmapped index
      endcase
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // start addresses and offsets, in 8-byte units
  // ----------------------------------------------------------------
  logic              dual_panel;
  logic [LINE_W-1:0] rq1_start;
  logic [LINE_W-1:0] rq2_start;
  logic [LINE_W-1:0] wq_start;
  logic [9:0]        rq1_ofs;
  logic [9:0]        rq2_ofs;
  logic [9:0]        wq_ofs;

  // dstn with virtual refresh splits the panel into two halves
  assign dual_panel = (panel_type_select_i == PANEL_DSTN) &&
                      virtual_refresh_control_i;
  // first queue feeds the upper half in split mode
  assign upper_panel_mode_o = dual_panel;

  // bits 18:16 from the overflow register
  assign rq1_start = LINE_W'({rd_addr_ovf_q[RD_OVF_Q1_START_LSB +: 3],
                              first_read_start_i});
  // high byte gives bits 15:8, overflow gives 18:16
  assign rq2_start = LINE_W'({rd_addr_ovf_q[RD_OVF_Q2_START_LSB +: 3],
                              rq2_start_hi_q, second_read_start_lo_i});
  // low byte on address 10:3, high on 18:11, overflow on 21:19
  assign wq_start  = LINE_W'({wr_addr_ovf_q[WR_OVF_START_LSB +: 3],
                              wr_start_hi_q, wr_start_lo_q});
  // the three fields above stack from address bit 3

  // offset low byte is address 10:3, top pair is address 12:11
  assign rq1_ofs = {rd_addr_ovf_q[RD_OVF_Q1_OFS_LSB +: 2],
                    rq1_ofs_lo_q};
  assign rq2_ofs = {rq2_ofs_ovf_q[Q2_OFS_OVF_LSB +: 2],
                    rq2_ofs_lo_q};
  assign wq_ofs  = {wr_addr_ovf_q[WR_OVF_OFS_LSB +: 2],
                    wr_ofs_lo_q};

  // ----------------------------------------------------------------
  // line address counters
  // ----------------------------------------------------------------
  logic [LINE_W-1:0] rq1_line_q;
  logic [LINE_W-1:0] rq2_line_q;
  logic [LINE_W-1:0] wq_line_q;

  // first read queue: reload at frame start, then add offset per line
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rq1_line_q <= '0;
    end else if (frame_start_i) begin
      rq1_line_q <= rq1_start;
    end else if (rq1_line_next_i) begin
      rq1_line_q <= rq1_line_q + LINE_W'(rq1_ofs);
    end
  end

  // second read queue only walks in split mode; otherwise it is idle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rq2_line_q <= '0;
    end else if (frame_start_i && dual_panel) begin
      rq2_line_q <= rq2_start;
    end else if (rq2_line_next_i && dual_panel) begin
      rq2_line_q <= rq2_line_q + LINE_W'(rq2_ofs);
    end
  end

  // write frame buffer line counter
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wq_line_q <= '0;
    end else if (frame_start_i) begin
      wq_line_q <= wq_start;
    end else if (wq_line_next_i) begin
      wq_line_q <= wq_line_q + LINE_W'(wq_ofs);
    end
  end

  assign rq1_addr_o = to_addr(rq1_line_q);
  assign rq2_addr_o = to_addr(rq2_line_q);
  assign wq_addr_o  = to_addr(wq_line_q);

  // ----------------------------------------------------------------
  // memory requests
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] rq1_lvl;
  logic [CNT_W-1:0] rq2_lvl;
  logic [CNT_W-1:0] wq_lvl;

  assign rq1_lvl = lvl_entries(req_levels_q[LVL_Q1_LSB +: 2]);
  assign rq2_lvl = lvl_entries(req_levels_q[LVL_Q2_LSB +: 2]);
  assign wq_lvl  = lvl_entries(req_levels_q[LVL_WR_LSB +: 2]);

  // combinational: the arbiter sees the level the same cycle it changes,
  // so a request never outlives the condition that raised it
  assign rq1_req_o = (rq1_empty_i >= rq1_lvl);
  assign rq2_req_o = dual_panel &&
                     (second_read_queue_empty_i >= rq2_lvl);
  assign wq_req_o  = (write_queue_filled_i >= wq_lvl);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // power-on value must be there on the first edge out of reset
  a_req_level_reset: assert property (
    $rose(rst_n_i) |-> req_levels_q == REQ_LEVELS_RST)
    else $error("request level register not at power-on value");

  // reserved low bits of the second offset overflow read back zero
  a_rsvd_read_zero: assert property (
    (reg_rd_i && reg_idx_i == IDX_RQ2_OFS_OVF) |=> reg_rdata_o[5:0] == 6'h0)
    else $error("reserved offset overflow bits read nonzero");

  // reserved top bits of the write overflow read back zero
  a_rsvd_wr_ovf: assert property (
    (reg_rd_i && reg_idx_i == IDX_WR_ADDR_OVF) |=> reg_rdata_o[7:5] == 3'h0)
    else $error("reserved write overflow bits read nonzero");

  // a write never touches the reserved request level field
  a_lvl_rsvd_keep: assert property (
    (reg_wr_i && reg_idx_i == IDX_REQ_LEVELS) |=>
      req_levels_q[3:2] == $past(req_levels_q[3:2]))
    else $error("reserved request level bits changed by a write");

  // first queue reload: overflow 5:3 on top of the 16-bit start
  a_rq1_frame_reload: assert property (
    frame_start_i |=> rq1_addr_o == ADDR_W'({$past(rd_addr_ovf_q[5:3]),
      $past(first_read_start_i), 3'b000}))
    else $error("first read line counter did not reload");

  // first queue step: overflow 7:6 above the low offset byte
  a_rq1_line_step: assert property (
    (!frame_start_i && rq1_line_next_i) |=>
      rq1_addr_o == $past(rq1_addr_o) + ADDR_W'({$past(rd_addr_ovf_q[7:6]),
        $past(rq1_ofs_lo_q), 3'b000}))
    else $error("first read address did not step by offset");

  // no lower panel request unless the panel is split
  a_rq2_idle_single: assert property (
    !dual_panel |-> !rq2_req_o)
    else $error("second read request outside split mode");

  // lower panel address frozen outside split mode
  a_rq2_frozen: assert property (
    !dual_panel |=> $stable(rq2_addr_o))
    else $error("second read address moved outside split mode");

  // lower panel reload: overflow 2:0, high byte, low byte port
  a_rq2_frame_map: assert property (
    (frame_start_i && dual_panel) |=> rq2_addr_o ==
      ADDR_W'({$past(rd_addr_ovf_q[2:0]), $past(rq2_start_hi_q),
        $past(second_read_start_lo_i), 3'b000}))
    else $error("second read start address bits misplaced");

  // lower panel step uses its own offset pair
  a_rq2_line_step: assert property (
    (dual_panel && !frame_start_i && rq2_line_next_i) |=>
      rq2_addr_o == $past(rq2_addr_o) + ADDR_W'({$past(rq2_ofs_ovf_q[7:6]),
        $past(rq2_ofs_lo_q), 3'b000}))
    else $error("second read line did not step by offset");

  // write start fields stack from address bit 3
  a_wq_start_map: assert property (
    frame_start_i |=> wq_addr_o[10:3] == $past(wr_start_lo_q) &&
      wq_addr_o[18:11] == $past(wr_start_hi_q) &&
      wq_addr_o[21:19] == $past(wr_addr_ovf_q[4:2]))
    else $error("write start address bits misplaced");

  // write step: overflow 1:0 above the low offset byte
  a_wq_line_step: assert property (
    (!frame_start_i && wq_line_next_i) |=>
      wq_addr_o == $past(wq_addr_o) + ADDR_W'({$past(wr_addr_ovf_q[1:0]),
        $past(wr_ofs_lo_q), 3'b000}))
    else $error("write line did not step by offset");

  // write line holds between strobes
  a_hold_no_line: assert property (
    (!frame_start_i && !wq_line_next_i) |=> $stable(wq_line_q))
    else $error("write line changed without a strobe");

  // threshold decoded here apart from the design's helper
  a_rq1_req_level: assert property (
    rq1_req_o == (req_levels_q[5] ? rq1_empty_i >= LVL_ENTRIES_12 :
                  req_levels_q[4] ? rq1_empty_i >= LVL_ENTRIES_8 :
                                    rq1_empty_i >= LVL_ENTRIES_4))
    else $error("first read request disagrees with level");

  // one entry short of the eight mark must not request
  a_rq2_req_below: assert property (
    (req_levels_q[7:6] == 2'b01 &&
     second_read_queue_empty_i == CNT_W'(7)) |-> !rq2_req_o)
    else $error("second read request raised below eight entries");

  // twelve empty entries satisfy every code in split mode
  a_rq2_req_full: assert property (
    (dual_panel && second_read_queue_empty_i >= CNT_W'(LVL_ENTRIES_12))
      |-> rq2_req_o)
    else $error("second read request missing at twelve entries");

  // three filled entries are below the four mark
  a_wq_req_four: assert property (
    (req_levels_q[1:0] == 2'b00 && write_queue_filled_i == CNT_W'(3)) |->
      !wq_req_o)
    else $error("write request raised below four entries");

  // twelve filled entries satisfy every code
  a_wq_req_full: assert property (
    (write_queue_filled_i >= CNT_W'(LVL_ENTRIES_12)) |-> wq_req_o)
    else $error("write request missing at twelve entries");

  // upper half flag only for dstn with virtual refresh
  a_upper_panel_mode: assert property (
    upper_panel_mode_o == (panel_type_select_i == 2'b01 &&
                           virtual_refresh_control_i))
    else $error("upper panel flag disagrees with panel mode");

  c_split_frame: cover property (frame_start_i && dual_panel);
  c_tft_frame: cover property (frame_start_i && !dual_panel);
  c_all_requests: cover property (rq1_req_o && rq2_req_o && wq_req_o);
  c_line_steps: cover property (rq1_line_next_i ##1 rq1_line_next_i);
  c_level_write: cover property (reg_wr_i && reg_idx_i == IDX_REQ_LEVELS);

endmodule : lcdfb_addr_gen

/* test/lcdfb_mem_model.sv */
// display memory arbiter model: holds queue levels and serves requests
`timescale 1ns/1ps

module lcdfb_mem_model #(
  parameter int CNT_W = 5
) (
  // clock
  input  wire logic             core_clk_i,
  // level loading from the bench
  input  wire logic [1:0]       lvl_sel_i,
  input  wire logic [CNT_W-1:0] lvl_val_i,
  input  wire logic             lvl_ld_i,
  input  wire logic             serve_i,
  // requests in, queue levels out
  input  wire logic [2:0]       req_i,
  output logic      [CNT_W-1:0] rq1_empty_o,
  output logic      [CNT_W-1:0] rq2_empty_o,
  output logic      [CNT_W-1:0] wq_filled_o
);
  logic [CNT_W-1:0] lvl_q [3] = '{default: '0};

  // one burst of four entries per served cycle, only while requested
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (lvl_ld_i && lvl_sel_i == 2'(i)) begin
        lvl_q[i] <= lvl_val_i;
      end else if (serve_i && req_i[i] && lvl_q[i] >= CNT_W'(4)) begin
        lvl_q[i] <= lvl_q[i] - CNT_W'(4);
      end
    end
  end

  // level outputs
  assign rq1_empty_o = lvl_q[0];
  assign rq2_empty_o = lvl_q[1];
  assign wq_filled_o = lvl_q[2];
endmodule : lcdfb_mem_model

/* test/tb.sv */
// self-checking testbench for the frame buffer address generator
`timescale 1ns/1ps

module tb
  import lcdfb_pkg::*;
;
  logic        core_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0]  reg_idx_i = 0, reg_wdata_i = 0, second_read_start_lo_i = 0;
  logic [1:0]  panel_type_select_i = 0, lvl_sel = 0;
  logic        virtual_refresh_control_i = 0, lvl_ld = 0, serve = 0;
  logic [15:0] first_read_start_i = 0;
  logic [3:0]  stb = 0;
  logic [4:0]  lvl_val = 0, rq1_empty, rq2_empty, wq_filled;
  logic [7:0]  reg_rdata_o;
  logic [21:0] rq1_addr_o, rq2_addr_o, wq_addr_o, e1, e2, ew;
  wire  [2:0]  reqs;
  logic        upper_panel_mode_o;
  int          failures = 0, total_checks = 0;

  // ----------------------------------------------------------------
  // clock, design and arbiter model
  // ----------------------------------------------------------------
  always #2.5 core_clk_i = ~core_clk_i;

  lcdfb_addr_gen i_lcdfb_addr_gen (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .panel_type_select_i(panel_type_select_i),
    .virtual_refresh_control_i(virtual_refresh_control_i),
    .first_read_start_i(first_read_start_i),
    .second_read_start_lo_i(second_read_start_lo_i),
    .frame_start_i(stb[0]), .rq1_line_next_i(stb[1]),
    .rq2_line_next_i(stb[2]), .wq_line_next_i(stb[3]),
    .rq1_empty_i(rq1_empty), .second_read_queue_empty_i(rq2_empty),
    .write_queue_filled_i(wq_filled), .rq1_addr_o(rq1_addr_o),
    .rq2_addr_o(rq2_addr_o), .wq_addr_o(wq_addr_o), .rq1_req_o(reqs[0]),
    .rq2_req_o(reqs[1]), .wq_req_o(reqs[2]),
    .upper_panel_mode_o(upper_panel_mode_o));

  lcdfb_mem_model i_lcdfb_mem_model (.core_clk_i(core_clk_i),
    .lvl_sel_i(lvl_sel), .lvl_val_i(lvl_val), .lvl_ld_i(lvl_ld),
    .serve_i(serve), .req_i(reqs), .rq1_empty_o(rq1_empty),
    .rq2_empty_o(rq2_empty), .wq_filled_o(wq_filled));

  // ----------------------------------------------------------------
  // compare, access and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [21:0] got, input logic [21:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_idx_i = idx;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge core_clk_i);
    reg_wr_i = 0;
  endtask : reg_write

  // read data is registered: look one edge after the strobe is taken
  task automatic reg_check(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge core_clk_i);
    reg_idx_i = idx;
    reg_rd_i = 1;
    @(negedge core_clk_i);
    reg_rd_i = 0;
    chk_val(22'(reg_rdata_o), 22'(exp));
  endtask : reg_check

  // bit 0 frame start, 1..3 line advance of rq1, rq2, wq
  task automatic pulse(input int which);
    @(negedge core_clk_i);
    stb[which] = 1;
    @(negedge core_clk_i);
    stb = 0;
  endtask : pulse

  task automatic set_lvl(input logic [1:0] q, input logic [4:0] v);
    @(negedge core_clk_i);
    lvl_sel = q;
    lvl_val = v;
    lvl_ld = 1;
    @(negedge core_clk_i);
    lvl_ld = 0;
    #1;
  endtask : set_lvl

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    failures++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] idx, ex;
    logic [4:0] thr;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1;
    reg_check(IDX_REQ_LEVELS, 8'h44);
    reg_write(8'h50, 8'hFF);
    reg_check(8'h50, 8'h00);
    // all ones then all zeros: reserved bits must not stick
    for (int v = 0; v < 2; v++) begin
      for (int i = 8'h43; i <= 8'h4C; i++) begin
        idx = 8'(i);
        ex = (v == 0) ? 8'hFF : 8'h00;
        if (idx == IDX_WR_ADDR_OVF) ex &= 8'h1F;
        if (idx == IDX_REQ_LEVELS) ex = (ex & 8'hF3) | 8'h04;
        if (idx == IDX_RQ2_OFS_OVF) ex &= 8'hC0;
        reg_write(idx, (v == 0) ? 8'hFF : 8'h00);
        reg_check(idx, ex);
      end
    end
    // program the three address generators, split dstn mode on
    reg_write(IDX_RQ2_START_HI, 8'h5E);
    reg_write(IDX_RQ1_OFS_LO, 8'h81);
    reg_write(IDX_RD_ADDR_OVF, 8'hAB);
    reg_write(IDX_WR_START_LO, 8'hFF);
    reg_write(IDX_WR_START_HI, 8'h12);
    reg_write(IDX_WR_OFS_LO, 8'hFF);
    reg_write(IDX_WR_ADDR_OVF, 8'h1F);
    reg_write(IDX_RQ2_OFS_LO, 8'h07);
    reg_write(IDX_RQ2_OFS_OVF, 8'hC0);
    first_read_start_i = 16'hABCD;
    second_read_start_lo_i = 8'h33;
    panel_type_select_i = 2'b01;
    virtual_refresh_control_i = 1;
    e1 = {3'b101, 16'hABCD, 3'h0};
    e2 = {3'b011, 8'h5E, 8'h33, 3'h0};
    ew = {3'b111, 8'h12, 8'hFF, 3'h0};
    for (int f = 0; f < 2; f++) begin
      pulse(0);
      chk_flag(upper_panel_mode_o, 1'b1);
      chk_val(rq1_addr_o, e1);
      chk_val(rq2_addr_o, e2);
      chk_val(wq_addr_o, ew);
      for (int l = 0; l < 2; l++) begin
        pulse(1);
        pulse(2);
        pulse(3);
        chk_val(rq1_addr_o, e1 + 22'({10'h281, 3'h0} * (l + 1)));
        chk_val(rq2_addr_o, e2 + 22'({10'h307, 3'h0} * (l + 1)));
        chk_val(wq_addr_o, ew + 22'({10'h3FF, 3'h0} * (l + 1)));
      end
    end
    // request thresholds for every code of every queue
    for (int q = 0; q < 3; q++) begin
      for (int c = 0; c < 4; c++) begin
        ex = (q == 0) ? 8'(c << 4) : (q == 1) ? 8'(c << 6) : 8'(c);
        reg_write(IDX_REQ_LEVELS, ex);
        thr = (c == 0) ? 5'd4 : (c == 1) ? 5'd8 : 5'd12;
        set_lvl(2'(q), thr - 5'd1);
        chk_flag(reqs[q], 1'b0);
        set_lvl(2'(q), thr);
        chk_flag(reqs[q], 1'b1);
        set_lvl(2'(q), 5'd16);
        chk_flag(reqs[q], 1'b1);
      end
      set_lvl(2'(q), 5'd0);
    end
    // serving drains the request once the level falls below the mark
    reg_write(IDX_REQ_LEVELS, 8'h10);
    set_lvl(2'd0, 5'd12);
    @(negedge core_clk_i);
    serve = 1;
    repeat (3) @(negedge core_clk_i);
    serve = 0;
    chk_flag(reqs[0], 1'b0);
    chk_val(22'(rq1_empty), 22'd4);
    // tft panel: second queue ignored, its request held low
    panel_type_select_i = 2'b00;
    set_lvl(2'd1, 5'd16);
    chk_flag(upper_panel_mode_o, 1'b0);
    chk_flag(reqs[1], 1'b0);
    // lower panel still sits two lines into the last split frame
    e2 = e2 + 22'({10'h307, 3'h0} * 2);
    pulse(2);
    chk_val(rq2_addr_o, e2);
    pulse(0);
    chk_val(rq1_addr_o, e1);
    chk_val(wq_addr_o, ew);
    chk_val(rq2_addr_o, e2);
    // dstn without virtual refresh is not split either
    panel_type_select_i = 2'b01;
    virtual_refresh_control_i = 0;
    #1;
    chk_flag(upper_panel_mode_o, 1'b0);
    chk_flag(reqs[1], 1'b0);
    print_verdict();
  end
endmodule : tb
